/* File: include/slice_pkg.sv */
package slice_pkg;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 11;
   localparam int SFR_IDX_W = 4;
   localparam logic [SFR_IDX_W-1:0] SFR_IDX_MIN = 4'h5;
   localparam logic [SFR_IDX_W-1:0] SFR_IDX_MAX = 4'hf;
   localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
   localparam logic [DATA_W-1:0] SFR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [PC_W-1:0] ONE_PC = 11'h001;

   localparam logic [7:0] WORK_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] PC_OFFSET = 8'h08;
   localparam logic [7:0] COUNT_OFFSET = 8'h0c;
   localparam int STATUS_ZERO_BIT = 0;
   localparam int STATUS_BUSY_BIT = 1;
   localparam int STATUS_BADIDX_BIT = 2;

   typedef enum logic [2:0] {
      INC_SKIP_ZERO_OP = 3'h0,
      OR_REG_OP = 3'h1,
      OR_IMMEDIATE_OP = 3'h2,
      SPECIAL_REG_READ_OP = 3'h3,
      SPECIAL_REG_WRITE_OP = 3'h4,
      SHORT_CALL_OP = 3'h5
   } op_kind_t;

   typedef enum logic [1:0] {
      EXEC_ST = 2'h0,
      SKIP_NOP_ST = 2'h1,
      CALL_ST = 2'h2
   } exec_state_t;
endpackage : slice_pkg

/* File: include/sfr_port_if.sv */
`timescale 1ns/1ps
interface sfr_port_if;
   logic we;
   logic [3:0] waddr;
   logic [7:0] wdata;
   logic [3:0] raddr;
   logic [7:0] rdata;
   modport core (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sfr_port_if

/* File: rtl/sfr_mem.sv */
`timescale 1ns/1ps
module sfr_mem (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   sfr_port_if.mem port
);
   localparam int DEPTH = 16;
   logic [slice_pkg::DATA_W-1:0] mem_q [DEPTH];
   logic [slice_pkg::DATA_W-1:0] rdata_q;

   // Read data registered; the core forwards it one cycle later
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rdata_q <= slice_pkg::SFR_RESET;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= slice_pkg::SFR_RESET;
         end
      end else if (ce_in) begin
         if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
         end
         rdata_q <= mem_q[port.raddr];
      end
   end

   assign port.rdata = rdata_q;
endmodule : sfr_mem

/* File: rtl/op_slice.sv */
`timescale 1ns/1ps
// Functional notes
// - Increment-skip adds one to file register 0..127; dest bit picks work or file.
// - Zero increment result discards fetched next instruction, NOP instead, two cycles.
// - Increment wraps modulo 256; 0xFF becomes 0x00 and skips.
// - Register OR: work OR file, dest bit picks target, zero flag, one cycle.
// - Immediate OR: work OR 8-bit immediate into work, zero flag, one cycle.
// - Special read copies F-page register 5..15 into work, flags untouched.
// - Special write loads F-page register 5..15 from work, flags untouched.
// - Short call pushes next address, loads 11-bit target into PC low bits, two cycles.
module op_slice (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic op_valid_in,
   output logic op_ready_out,
   input wire logic [2:0] op_kind_in,
   input wire logic [6:0] op_faddr_in,
   input wire logic op_dest_in,
   input wire logic [10:0] op_imm_in,
   input wire logic [10:0] op_pc_in,
   output logic [6:0] fr_raddr_out,
   input wire logic [7:0] fr_rdata_in,
   output logic fr_we_out,
   output logic [6:0] fr_waddr_out,
   output logic [7:0] fr_wdata_out,
   output logic discard_next_out,
   output logic stack_push_out,
   output logic [10:0] stack_data_out,
   output logic pc_load_out,
   output logic [10:0] pc_target_out,
   output logic [7:0] work_out,
   output logic zero_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   sfr_port_if sfr ();

   slice_pkg::exec_state_t state_q, state_d;
   logic [7:0] work_q, work_d;
   logic zero_q, zero_d;
   logic sfr_load_q;
   logic badidx_q;
   logic [7:0] op_count_q;
   logic fr_we_q;
   logic [6:0] fr_waddr_q;
   logic [7:0] fr_wdata_q;
   logic discard_q;
   logic push_q;
   logic [10:0] push_data_q;
   logic pc_load_q;
   logic [10:0] pc_target_q;

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction : is_zero

   // Forwarding hides the registered read latency of the special registers
   wire [7:0] work_now = sfr_load_q ? sfr.rdata : work_q;
   wire accept = op_valid_in && op_ready_out;
   wire [7:0] inc_res = fr_rdata_in + slice_pkg::ONE_BYTE;
   wire [7:0] or_reg_res = work_now | fr_rdata_in;
   wire [7:0] or_imm_res = work_now | op_imm_in[7:0];
   wire idx_ok = op_faddr_in[3:0] >= slice_pkg::SFR_IDX_MIN &&
      op_faddr_in[3:0] <= slice_pkg::SFR_IDX_MAX && op_faddr_in[6:4] == 3'h0;
   wire is_inc = accept && op_kind_in == slice_pkg::INC_SKIP_ZERO_OP;
   wire is_or_reg = accept && op_kind_in == slice_pkg::OR_REG_OP;
   wire is_or_imm = accept && op_kind_in == slice_pkg::OR_IMMEDIATE_OP;
   wire is_sfr_rd = accept && op_kind_in == slice_pkg::SPECIAL_REG_READ_OP;
   wire is_sfr_wr = accept && op_kind_in == slice_pkg::SPECIAL_REG_WRITE_OP;
   wire is_call = accept && op_kind_in == slice_pkg::SHORT_CALL_OP;
   wire to_file = op_dest_in;

   wire apb_access = psel && penable;
   wire apb_wr = apb_access && pwrite;
   wire sel_work = paddr == slice_pkg::WORK_OFFSET;
   wire sel_status = paddr == slice_pkg::STATUS_OFFSET;
   wire sel_pc = paddr == slice_pkg::PC_OFFSET;
   wire sel_count = paddr == slice_pkg::COUNT_OFFSET;
   wire mapped = sel_work || sel_status || sel_pc || sel_count;

   assign op_ready_out = state_q == slice_pkg::EXEC_ST;
   assign fr_raddr_out = op_faddr_in;
   assign sfr.raddr = op_faddr_in[3:0];
   assign sfr.we = is_sfr_wr && idx_ok;
   assign sfr.waddr = op_faddr_in[3:0];
   assign sfr.wdata = work_now;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         slice_pkg::EXEC_ST: begin
            if (is_inc && is_zero(inc_res)) begin
               state_d = slice_pkg::SKIP_NOP_ST;
            end else if (is_call) begin
               state_d = slice_pkg::CALL_ST;
            end
         end
         slice_pkg::SKIP_NOP_ST: state_d = slice_pkg::EXEC_ST;
         slice_pkg::CALL_ST: state_d = slice_pkg::EXEC_ST;
         default: state_d = slice_pkg::EXEC_ST;
      endcase
   end

   always_comb begin
      work_d = work_now;
      zero_d = zero_q;
      if (is_inc && !to_file) begin
         work_d = inc_res;
      end else if (is_or_reg) begin
         zero_d = is_zero(or_reg_res);
         if (!to_file) begin
            work_d = or_reg_res;
         end
      end else if (is_or_imm) begin
         work_d = or_imm_res;
         zero_d = is_zero(or_imm_res);
      end else if (accept) begin
         work_d = work_now;
      end else if (apb_wr && sel_work) begin
         work_d = pwdata[7:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         state_q <= slice_pkg::EXEC_ST;
         work_q <= slice_pkg::WORK_RESET;
         zero_q <= 1'b0;
         sfr_load_q <= 1'b0;
         badidx_q <= 1'b0;
         op_count_q <= 8'h00;
      end else if (ce_in) begin
         state_q <= state_d;
         work_q <= work_d;
         zero_q <= zero_d;
         sfr_load_q <= is_sfr_rd && idx_ok;
         if ((is_sfr_rd || is_sfr_wr) && !idx_ok) begin
            badidx_q <= 1'b1;
         end else if (apb_wr && sel_status && pwdata[slice_pkg::STATUS_BADIDX_BIT]) begin
            badidx_q <= 1'b0;
         end
         if (accept) begin
            op_count_q <= op_count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         fr_we_q <= 1'b0;
         fr_waddr_q <= 7'h00;
         fr_wdata_q <= 8'h00;
         discard_q <= 1'b0;
      end else if (ce_in) begin
         fr_we_q <= (is_inc || is_or_reg) && to_file;
         fr_waddr_q <= op_faddr_in;
         fr_wdata_q <= is_inc ? inc_res : or_reg_res;
         discard_q <= is_inc && is_zero(inc_res);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         push_q <= 1'b0;
         push_data_q <= 11'h000;
         pc_load_q <= 1'b0;
         pc_target_q <= 11'h000;
      end else if (ce_in) begin
         push_q <= is_call;
         pc_load_q <= is_call;
         if (is_call) begin
            push_data_q <= op_pc_in + slice_pkg::ONE_PC;
            pc_target_q <= op_imm_in;
         end
      end
   end

   sfr_mem u_sfr_mem (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .port(sfr)
   );

   wire [31:0] status_word = {29'h0000_0000, badidx_q, !op_ready_out, zero_q};

   assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
      sel_work ? {24'h00_0000, work_now} :
      sel_status ? status_word :
      sel_pc ? {21'h00_0000, pc_target_q} :
      sel_count ? {24'h00_0000, op_count_q} : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = apb_access && !mapped;

   assign fr_we_out = fr_we_q;
   assign fr_waddr_out = fr_waddr_q;
   assign fr_wdata_out = fr_wdata_q;
   assign discard_next_out = discard_q;
   assign stack_push_out = push_q;
   assign stack_data_out = push_data_q;
   assign pc_load_out = pc_load_q;
   assign pc_target_out = pc_target_q;
   assign work_out = work_now;
   assign zero_out = zero_q;
endmodule : op_slice

/* File: tb/op_slice_properties.sv */
`timescale 1ns/1ps
module op_slice_properties (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic op_valid_in,
   input wire logic op_ready_out,
   input wire logic [2:0] op_kind_in,
   input wire logic [6:0] op_faddr_in,
   input wire logic op_dest_in,
   input wire logic [10:0] op_imm_in,
   input wire logic [10:0] op_pc_in,
   input wire logic [7:0] fr_rdata_in,
   input wire logic fr_we_out,
   input wire logic [6:0] fr_waddr_out,
   input wire logic [7:0] fr_wdata_out,
   input wire logic discard_next_out,
   input wire logic stack_push_out,
   input wire logic [10:0] stack_data_out,
   input wire logic pc_load_out,
   input wire logic [10:0] pc_target_out,
   input wire logic [7:0] work_out,
   input wire logic zero_out
);
   wire logic tk = op_valid_in & op_ready_out & ce_in;
   wire logic [7:0] inc_v = fr_rdata_in + 8'h01;
   wire logic [7:0] orr_v = work_out | fr_rdata_in;
   wire logic [7:0] ori_v = work_out | op_imm_in[7:0];
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   a_inc_to_file: assert property (tk && op_kind_in == 3'h0 && op_dest_in |=>
      fr_we_out && fr_wdata_out == $past(inc_v) && fr_waddr_out == $past(op_faddr_in))
      else $error("increment file write wrong");
   a_inc_to_work: assert property (tk && op_kind_in == 3'h0 && !op_dest_in |=>
      !fr_we_out && work_out == $past(inc_v)) else $error("increment work result wrong");
   a_zero_skips: assert property (tk && op_kind_in == 3'h0 &&
      fr_rdata_in == 8'hff |=>
      discard_next_out && !op_ready_out ##1 op_ready_out) else $error("skip missing");
   a_no_skip: assert property (tk && op_kind_in == 3'h0 && fr_rdata_in != 8'hff |=>
      !discard_next_out && op_ready_out) else $error("unexpected skip");
   a_or_reg_result: assert property (tk && op_kind_in == 3'h1 |=>
      ($past(op_dest_in) ? fr_we_out && fr_wdata_out == $past(orr_v) : work_out == $past(orr_v))
      && zero_out == ($past(orr_v) == 8'h00)) else $error("register or wrong");
   a_or_imm_result: assert property (tk && op_kind_in == 3'h2 |=>
      work_out == $past(ori_v) && zero_out == (work_out == 8'h00))
      else $error("immediate or wrong");
   a_sfr_flag_kept: assert property (tk &&
      (op_kind_in == 3'h3 || op_kind_in == 3'h4) |=>
      $stable(zero_out) && !fr_we_out) else $error("special access touched flag");
   a_sfr_write_work: assert property (tk && op_kind_in == 3'h4 |=> $stable(work_out))
      else $error("special write changed work");
   a_call_push: assert property (tk && op_kind_in == 3'h5 |=>
      stack_push_out && pc_load_out && !op_ready_out && stack_data_out == $past(op_pc_in) + 11'h001
      && pc_target_out == $past(op_imm_in) ##1 !stack_push_out && op_ready_out)
      else $error("call push or target wrong");
endmodule : op_slice_properties

bind op_slice op_slice_properties chk_i (.core_clk_in, .resetn_in, .ce_in, .op_valid_in,
   .op_ready_out, .op_kind_in, .op_faddr_in, .op_dest_in, .op_imm_in, .op_pc_in, .fr_rdata_in,
   .fr_we_out, .fr_waddr_out, .fr_wdata_out, .discard_next_out, .stack_push_out,
   .stack_data_out, .pc_load_out, .pc_target_out, .work_out, .zero_out);

/* File: tb/mcu_incr_or_sfr_call_ops_test.sv */
`timescale 1ns/1ps
module mcu_incr_or_sfr_call_ops_test;
   logic core_clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1, op_valid_in = 1'b0, op_dest_in = 1'b0;
   logic [2:0] op_kind_in = 3'h0;
   logic [6:0] op_faddr_in = 7'h00;
   logic [10:0] op_imm_in = 11'h000, op_pc_in = 11'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, q;
   logic [7:0] fmem [128];
   logic [7:0] sfr [16];
   logic [7:0] w;
   logic z, bad, e;
   int seed = 32'h161c, n_fail = 0, n_tests = 0, n_ops = 0, cyc = 0;
   wire logic op_ready_out, fr_we_out, discard_next_out, stack_push_out, pc_load_out, zero_out;
   wire logic pready, pslverr;
   wire logic [6:0] fr_raddr_out, fr_waddr_out;
   wire logic [7:0] fr_wdata_out, work_out;
   wire logic [10:0] stack_data_out, pc_target_out;
   wire logic [31:0] prdata;
   wire logic [7:0] fr_rdata_in = fmem[fr_raddr_out];
   op_slice uut (.core_clk_in, .resetn_in, .ce_in, .op_valid_in, .op_ready_out, .op_kind_in,
      .op_faddr_in, .op_dest_in, .op_imm_in, .op_pc_in, .fr_raddr_out, .fr_rdata_in, .fr_we_out,
      .fr_waddr_out, .fr_wdata_out, .discard_next_out, .stack_push_out, .stack_data_out,
      .pc_load_out, .pc_target_out, .work_out, .zero_out, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   initial forever #5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      if (fr_we_out) fmem[fr_waddr_out] <= fr_wdata_out;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         test_done();
      end
   end
   task test_done;
      $display("Checks %0d, errors %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         n_fail++;
         $display("Error %0s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   function automatic logic [7:0] res(input logic [2:0] k, input logic [7:0] r, i);
      return k == 3'h0 ? r + 8'h01 : (k == 3'h1 ? w | r : w | i);
   endfunction : res
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do @(posedge core_clk_in); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task op(input logic [2:0] k, input logic [6:0] a, input logic d, input logic [10:0] i, p);
      logic [7:0] r, x;
      logic ok;
      r = fmem[a];
      x = res(k, r, i[7:0]);
      ok = a >= 7'd5 && a <= 7'd15;
      @(posedge core_clk_in);
      op_valid_in <= 1'b1;
      op_kind_in <= k;
      op_faddr_in <= a;
      op_dest_in <= d;
      op_imm_in <= i;
      op_pc_in <= p;
      @(posedge core_clk_in);
      op_valid_in <= 1'b0;
      n_ops++;
      #1;
      chk("file write", fr_we_out, d && k <= 3'h1);
      if (d && k <= 3'h1) begin
         chk("file data", {fr_waddr_out, fr_wdata_out}, {a, x});
      end
      chk("discard", discard_next_out, k == 3'h0 && x == 8'h00);
      chk("ready", op_ready_out, !(k == 3'h5 || (k == 3'h0 && x == 8'h00)));
      chk("push load", {stack_push_out, pc_load_out}, {2{k == 3'h5}});
      if (k == 3'h5) chk("call", {stack_data_out, pc_target_out}, {p + 11'h001, i});
      if (k == 3'h2 || (k <= 3'h1 && !d)) w = x;
      if (k == 3'h1 || k == 3'h2) z = x == 8'h00;
      if (k == 3'h3 && ok) w = sfr[a[3:0]];
      if (k == 3'h4 && ok) sfr[a[3:0]] = w;
      if (k >= 3'h3 && k <= 3'h4 && !ok) bad = 1'b1;
      @(posedge core_clk_in);
      #1;
      chk("work", work_out, w);
      chk("zero", zero_out, z);
   endtask : op
   initial begin
      for (int n = 0; n < 128; n++) fmem[n] = 8'($random(seed));
      for (int n = 0; n < 16; n++) sfr[n] = 8'h00;
      w = 8'h00;
      z = 1'b0;
      bad = 1'b0;
      fmem[9] = 8'hff;
      fmem[10] = 8'hff;
      repeat (2) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      apb(1'b0, slice_pkg::STATUS_OFFSET, 32'h0);
      chk("status reset", q, 32'h0);
      apb(1'b1, slice_pkg::WORK_OFFSET, 32'h5a);
      apb(1'b0, slice_pkg::WORK_OFFSET, 32'h0);
      w = 8'h5a;
      chk("work rw", q, 32'h5a);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", e, 1'b1);
      chk("unmapped data", q, 32'h0);
      apb(1'b1, 8'h10, 32'h77);
      chk("unmapped write err", e, 1'b1);
      // Clock enable low must freeze the work register against bus writes too
      @(posedge core_clk_in);
      ce_in <= 1'b0;
      apb(1'b1, slice_pkg::WORK_OFFSET, 32'h33);
      ce_in <= 1'b1;
      apb(1'b0, slice_pkg::WORK_OFFSET, 32'h0);
      chk("work frozen", q, {24'h00_0000, w});
      // Wrap cases first: ff to 00 both destinations, then a call at the top of PC space
      op(3'h0, 7'd9, 1'b1, 11'h0, 11'h0);
      op(3'h0, 7'd10, 1'b0, 11'h0, 11'h0);
      op(3'h0, 7'd9, 1'b0, 11'h0, 11'h0);
      op(3'h5, 7'd0, 1'b0, 11'h123, 11'h7ff);
      op(3'h3, 7'd2, 1'b0, 11'h0, 11'h0);
      apb(1'b0, slice_pkg::STATUS_OFFSET, 32'h0);
      chk("status", q, {bad, 1'b0, z});
      apb(1'b1, slice_pkg::STATUS_OFFSET, 32'h4);
      apb(1'b0, slice_pkg::STATUS_OFFSET, 32'h0);
      chk("status clear", q, {1'b0, 1'b0, z});
      apb(1'b0, slice_pkg::PC_OFFSET, 32'h0);
      chk("last target", q, 32'h123);
      apb(1'b0, slice_pkg::COUNT_OFFSET, 32'h0);
      chk("op count", q, n_ops[7:0]);
      repeat (80) begin
         logic [2:0] k;
         k = 3'($unsigned($random(seed)) % 6);
         op(k, k >= 3'h3 && k <= 3'h4 ? 7'(5 + $unsigned($random(seed)) % 11) : 7'($random(seed)),
            1'($random(seed)), 11'($random(seed)), 11'($random(seed)));
      end
      test_done();
   end
endmodule : mcu_incr_or_sfr_call_ops_test
